// ### hw/tmr_pkg.sv
// Constants, types and register map of the timer I/O mode block.
// Assumes one pclk domain and an APB master on the register side.
//
// Contract
// - Mode zero or level-only: compare, pin output off.
// - Bit 2 sets initial level; 01 drives low.
// - Action 10 drives pin high on match.
// - Action 11 toggles pin on every match.
// - Capture mode 00 loads counter on rising.
// - Capture mode 01 loads counter on falling.
// - Capture mode 1x loads on both edges.
// - Channel three 11xx captures on channel-four counts.
// - Register c captures from its own pin, or on channel-four counts in 11xx.
// - Buffer enable silences register c entirely.
`default_nettype none
package tmr_pkg;

  // ==========================================================
  // Register map, byte addresses.
  localparam int          AW        = 8;
  localparam int          GW        = 16;
  localparam logic [7:0]  ADDR_MODE = 8'h00;
  localparam logic [7:0]  ADDR_CTRL = 8'h04;
  localparam logic [7:0]  ADDR_GR2A = 8'h08;
  localparam logic [7:0]  ADDR_GR3A = 8'h0C;
  localparam logic [7:0]  ADDR_GR3C = 8'h10;
  localparam logic [7:0]  ADDR_STAT = 8'h14;

  // ==========================================================
  // Field layout.
  localparam int          F2A       = 0;
  localparam int          F3A       = 4;
  localparam int          F3C       = 8;
  localparam int          BUF_BIT   = 0;
  localparam int          ST_OUT    = 0;
  localparam int          ST_IN     = 4;
  localparam int          MB_CAP    = 3;
  localparam int          MB_LVL    = 2;
  localparam logic [1:0]  ACT_NONE  = 2'h0;
  localparam logic [1:0]  ACT_LOW   = 2'h1;
  localparam logic [1:0]  ACT_HIGH  = 2'h2;
  localparam logic [1:0]  ACT_TOG   = 2'h3;
  localparam logic [3:0]  MODE_RST  = 4'h0;
  localparam logic [15:0] GR_RST    = 16'hFFFF;

  // ==========================================================
  // Types.
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } sync_state_t;

  typedef struct packed {
    logic [3:0]    mode;
    logic [GW-1:0] gr;
    logic          pin;
    logic          cap_evt;
    logic          cmp_evt;
  } gen_ch_t;

  typedef struct packed {
    gen_ch_t       ch2a;
    gen_ch_t       ch3a;
    gen_ch_t       ch3c;
    logic          buf_a;
    logic [GW-1:0] prev2;
    logic [GW-1:0] prev3;
    logic [31:0]   prdata;
  } timer_state_t;

endpackage
`default_nettype wire

// ### hw/pin_sync.sv
// Three-stage pin synchroniser with filtered level and edge pulses.
// Assumes pin_in is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import tmr_pkg::*;
(
  input  wire logic pclk,    // Clock.
  input  wire logic presetn, // Async reset, active low.
  input  wire logic pin_in,  // Raw pin level.
  output logic      level,   // Accepted level.
  output logic      rise,    // One-cycle rising pulse.
  output logic      fall     // One-cycle falling pulse.
);

  sync_state_t st;
  sync_state_t next_st;

  // ==========================================================
  // A change is accepted once stages two and three agree.
  always_comb begin
    next_st      = st;
    next_st.s1   = pin_in;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    if (st.s2 == st.s3 && st.s3 != st.level) begin
      next_st.level = st.s3;
      next_st.rise  = st.s3;
      next_st.fall  = ~st.s3;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
  assign rise  = st.rise;
  assign fall  = st.fall;

endmodule
`default_nettype wire

// ### hw/timer_io_mode_select.sv
// I/O mode logic for general registers 2A, 3A and 3C of the timer.
// Assumes counters come from same-clock logic; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module timer_io_mode_select
  import tmr_pkg::*;
(
  input  wire logic          pclk,          // Clock, 250 MHz.
  input  wire logic          presetn,       // Async reset, active low.
  input  wire logic          psel,          // APB select.
  input  wire logic          penable,       // APB enable.
  input  wire logic          pwrite,        // APB direction.
  input  wire logic [AW-1:0] paddr,         // APB byte address.
  input  wire logic [31:0]   pwdata,        // APB write data.
  output logic [31:0]        prdata,        // APB read data.
  output logic               pready,        // APB ready.
  output logic               pslverr,       // APB error.
  input  wire logic [GW-1:0] ch2_counter,   // Channel 2 count.
  input  wire logic [GW-1:0] ch3_counter,   // Channel 3 count.
  input  wire logic          ch4_count_tick, // Channel 4 counted.
  input  wire logic          ch2_pin_a_in,  // Pin level in.
  input  wire logic          ch3_pin_a_in,  // Pin level in.
  input  wire logic          ch3_pin_c_in,  // Pin level in.
  output pin_drive_t         ch2_pin_a_drv, // Pin drive.
  output pin_drive_t         ch3_pin_a_drv, // Pin drive.
  output pin_drive_t         ch3_pin_c_drv, // Pin drive.
  output logic [2:0]         capture_evt,   // Capture pulses.
  output logic [2:0]         compare_evt    // Match pulses.
);

  timer_state_t st;
  timer_state_t next_st;
  logic         rise2, fall2, lvl2;
  logic         rise3a, fall3a, lvl3a;
  logic         rise3c, fall3c, lvl3c;
  logic         acc, wr, setup_rd, mapped;
  logic         wr_mode, wr_ctrl;
  logic         match2, match3a, match3c;

  // ==========================================================
  // Pin synchronisers.
  pin_sync u_sync2 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ch2_pin_a_in),
    .level   (lvl2),
    .rise    (rise2),
    .fall    (fall2)
  );

  pin_sync u_sync3a (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ch3_pin_a_in),
    .level   (lvl3a),
    .rise    (rise3a),
    .fall    (fall3a)
  );

  pin_sync u_sync3c (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (ch3_pin_c_in),
    .level   (lvl3c),
    .rise    (rise3c),
    .fall    (fall3c)
  );

  // ==========================================================
  // APB decode; zero wait states, unmapped accesses flag an error.
  assign acc      = psel & penable;
  assign wr       = acc & pwrite;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign mapped   = paddr == ADDR_MODE || paddr == ADDR_CTRL ||
                    paddr == ADDR_GR2A || paddr == ADDR_GR3A ||
                    paddr == ADDR_GR3C || paddr == ADDR_STAT;
  assign wr_mode  = wr && paddr == ADDR_MODE;
  assign wr_ctrl  = wr && paddr == ADDR_CTRL;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = st.prdata;

  // A match counts only on the cycle the counter reaches the value.
  assign match2  = ch2_counter == st.ch2a.gr && ch2_counter != st.prev2;
  assign match3a = ch3_counter == st.ch3a.gr && ch3_counter != st.prev3;
  assign match3c = ch3_counter == st.ch3c.gr && ch3_counter != st.prev3;

  // ==========================================================
  // One general register step: mode load, capture or compare.
  function automatic gen_ch_t step(
    input gen_ch_t       c,
    input logic          wm,
    input logic [3:0]    wmode,
    input logic          wg,
    input logic [GW-1:0] wgr,
    input logic [GW-1:0] cnt,
    input logic          match,
    input logic          rise,
    input logic          fall,
    input logic          alt_en,
    input logic          alt_cap,
    input logic          inhibit
  );
    gen_ch_t n;
    logic    cap;
    n         = c;
    cap       = 1'b0;
    n.cap_evt = 1'b0;
    n.cmp_evt = 1'b0;
    if (wg) begin
      n.gr = wgr;
    end
    if (wm) begin
      n.mode = wmode;
      n.pin  = wmode[MB_LVL];
    end else if (!inhibit) begin
      if (c.mode[MB_CAP]) begin
        if (alt_en && c.mode[MB_LVL]) begin
          cap = alt_cap;
        end else if (c.mode[1]) begin
          cap = rise | fall;
        end else if (c.mode[0]) begin
          cap = fall;
        end else begin
          cap = rise;
        end
        if (cap) begin
          n.gr      = cnt;
          n.cap_evt = 1'b1;
        end
      end else if (match) begin
        n.cmp_evt = 1'b1;
        case (c.mode[1:0])
          ACT_LOW:  n.pin = 1'b0;
          ACT_HIGH: n.pin = 1'b1;
          ACT_TOG:  n.pin = ~c.pin;
          default:  n.pin = c.pin;
        endcase
      end
    end
    return n;
  endfunction

  // Pin enabled only for compare with a match action.
  function automatic pin_drive_t drive(input gen_ch_t c,
                                       input logic inhibit);
    pin_drive_t d;
    d.out  = c.pin;
    d.oe_n = c.mode[MB_CAP] || c.mode[1:0] == ACT_NONE ||
             inhibit;
    return d;
  endfunction

  // ==========================================================
  // Next state.
  always_comb begin
    next_st        = st;
    next_st.prev2  = ch2_counter;
    next_st.prev3  = ch3_counter;
    // Channel two has no alternative capture source.
    next_st.ch2a = step(st.ch2a, wr_mode, pwdata[F2A +: 4],
                        wr && paddr == ADDR_GR2A, pwdata[GW-1:0],
                        ch2_counter, match2, rise2, fall2,
                        1'b0, 1'b0, 1'b0);
    next_st.ch3a = step(st.ch3a, wr_mode, pwdata[F3A +: 4],
                        wr && paddr == ADDR_GR3A, pwdata[GW-1:0],
                        ch3_counter, match3a, rise3a, fall3a,
                        1'b1, ch4_count_tick, 1'b0);
    // Register c watches its own pin, or channel-four counts in mode 11xx.
    next_st.ch3c = step(st.ch3c, wr_mode, pwdata[F3C +: 4],
                        wr && paddr == ADDR_GR3C, pwdata[GW-1:0],
                        ch3_counter, match3c, rise3c, fall3c,
                        1'b1, ch4_count_tick, st.buf_a);
    if (wr_ctrl) begin
      next_st.buf_a = pwdata[BUF_BIT];
    end
    if (setup_rd) begin
      next_st.prdata = '0;
      case (paddr)
        ADDR_MODE: begin
          next_st.prdata[F2A +: 4] = st.ch2a.mode;
          next_st.prdata[F3A +: 4] = st.ch3a.mode;
          next_st.prdata[F3C +: 4] = st.ch3c.mode;
        end
        ADDR_CTRL: next_st.prdata[BUF_BIT] = st.buf_a;
        ADDR_GR2A: next_st.prdata[GW-1:0] = st.ch2a.gr;
        ADDR_GR3A: next_st.prdata[GW-1:0] = st.ch3a.gr;
        ADDR_GR3C: next_st.prdata[GW-1:0] = st.ch3c.gr;
        ADDR_STAT: begin
          next_st.prdata[ST_OUT +: 3] = {st.ch3c.pin, st.ch3a.pin,
                                         st.ch2a.pin};
          next_st.prdata[ST_IN +: 3]  = {lvl3c, lvl3a, lvl2};
        end
        default: next_st.prdata = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st         <= '0;
      st.ch2a.gr <= GR_RST;
      st.ch3a.gr <= GR_RST;
      st.ch3c.gr <= GR_RST;
    end else begin
      st <= next_st;
    end
  end

  assign ch2_pin_a_drv = drive(st.ch2a, 1'b0);
  assign ch3_pin_a_drv = drive(st.ch3a, 1'b0);
  assign ch3_pin_c_drv = drive(st.ch3c, st.buf_a);
  assign capture_evt   = {st.ch3c.cap_evt, st.ch3a.cap_evt,
                          st.ch2a.cap_evt};
  assign compare_evt   = {st.ch3c.cmp_evt, st.ch3a.cmp_evt,
                          st.ch2a.cmp_evt};

  // ==========================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_rise2_capmode;
    st.ch2a.mode == 4'h8 && rise2 && !wr_mode;
  endsequence

  property p_off;
    st.ch2a.mode[MB_CAP] == 1'b0 && st.ch2a.mode[1:0] == ACT_NONE
      |-> ch2_pin_a_drv.oe_n;
  endproperty
  a_off: assert property (p_off) else $error("pin driven when off");

  property p_init;
    wr_mode && !pwdata[F2A + MB_CAP]
      |=> ch2_pin_a_drv.out == $past(pwdata[F2A + MB_LVL]);
  endproperty
  a_init: assert property (p_init) else $error("bad initial level");

  property p_high;
    st.ch2a.mode[MB_CAP:0] == 4'h2 && match2 && !wr_mode
      |=> ch2_pin_a_drv.out && compare_evt[0];
  endproperty
  a_high: assert property (p_high) else $error("no high on match");

  property p_tog;
    st.ch3a.mode[MB_CAP] == 1'b0 && st.ch3a.mode[1:0] == ACT_TOG &&
    match3a && !wr_mode |=> ch3_pin_a_drv.out != $past(st.ch3a.pin);
  endproperty
  a_tog: assert property (p_tog) else $error("no toggle on match");

  property p_cap_rise;
    s_rise2_capmode |=> st.ch2a.gr == $past(ch2_counter) ##1
      !capture_evt[0] || rise2 || fall2;
  endproperty
  a_cap_rise: assert property (p_cap_rise) else $error("rise miss");

  property p_cap_fall;
    st.ch3a.mode == 4'h9 && !wr_mode
      |-> ##1 (capture_evt[1] == $past(fall3a));
  endproperty
  a_cap_fall: assert property (p_cap_fall) else $error("fall miss");

  property p_cap_both;
    st.ch3a.mode == 4'hA && (rise3a || fall3a) && !wr_mode
      |=> capture_evt[1] && st.ch3a.gr == $past(ch3_counter);
  endproperty
  a_cap_both: assert property (p_cap_both) else $error("edge miss");

  property p_cap_ch4;
    st.ch3a.mode[MB_CAP:MB_LVL] == 2'h3 && !wr_mode
      |=> capture_evt[1] == $past(ch4_count_tick);
  endproperty
  a_cap_ch4: assert property (p_cap_ch4) else $error("ch4 miss");

  property p_pin_c;
    st.ch3c.mode == 4'h8 && !st.buf_a && !wr_mode
      |=> capture_evt[2] == $past(rise3c);
  endproperty
  a_pin_c: assert property (p_pin_c) else $error("pin c miss");

  property p_ch2_b2;
    st.ch2a.mode == 4'hC && rise2 && !wr_mode |=> capture_evt[0];
  endproperty
  a_ch2_b2: assert property (p_ch2_b2) else $error("bit2 used");

  property p_buf;
    st.buf_a |=> !capture_evt[2] && !compare_evt[2] ##0
      ($past(wr_ctrl) || ch3_pin_c_drv.oe_n);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer leaks");

endmodule
`default_nettype wire

// ### tb/pin_partner.sv
// Pin-side partner: external logic that drives the three timer pins.
// Assumes the device drives are {out, oe_n} structs, oe_n low = driving.
`timescale 1ns/1ps
`default_nettype none
module pin_partner
  import tmr_pkg::*;
(
  input  wire logic       pclk,  // Clock.
  input  wire pin_drive_t drv2a, // Device drive, pin 2A.
  input  wire pin_drive_t drv3a, // Device drive, pin 3A.
  input  wire pin_drive_t drv3c, // Device drive, pin 3C.
  output wire logic [2:0] pin    // Resolved levels {3C,3A,2A}.
);
  logic [2:0] lvl;

  initial lvl = 3'h0;

  // ==========================================================
  // Wire resolution.
  // The device owns a wire while it enables its driver.
  assign pin[0] = drv2a.oe_n ? lvl[0] : drv2a.out;
  assign pin[1] = drv3a.oe_n ? lvl[1] : drv3a.out;
  assign pin[2] = drv3c.oe_n ? lvl[2] : drv3c.out;

  task automatic drive(input logic [2:0] v);
    @(posedge pclk);
    lvl <= v;
  endtask
endmodule
`default_nettype wire

// ### tb/test_timer_io_mode_select.sv
// Self-checking bench for the timer I/O mode block.
// Assumes an APB slave with pready high and a pin partner model.
`timescale 1ns/1ps
`default_nettype none
module test_timer_io_mode_select
  import tmr_pkg::*;
;
  logic          pclk, presetn, psel, penable, pwrite, tick, run;
  logic [AW-1:0] paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic          pready, pslverr, err;
  logic [GW-1:0] cnt, tgt;
  logic [2:0]    pin, cap, cmp, seen;
  logic [1:0]    ex;
  pin_drive_t    d2, d3a, d3c;
  int            mismatches, tests_run, cycles;

  timer_io_mode_select uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ch2_counter(cnt), .ch3_counter(cnt), .ch4_count_tick(tick),
    .ch2_pin_a_in(pin[0]), .ch3_pin_a_in(pin[1]), .ch3_pin_c_in(pin[2]),
    .ch2_pin_a_drv(d2), .ch3_pin_a_drv(d3a), .ch3_pin_c_drv(d3c),
    .capture_evt(cap), .compare_evt(cmp));

  pin_partner far (.pclk(pclk), .drv2a(d2), .drv3a(d3a), .drv3c(d3c),
    .pin(pin));

  // ==========================================================
  // Clock, free counter and hang guard.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (run) cnt <= cnt + 16'h0001;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Tasks.
  task automatic tally_and_finish();
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [AW-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [AW-1:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0);
  endtask

  function automatic logic [31:0] m3(input logic [3:0] m);
    return {20'h0, m, m, m};
  endfunction

  task automatic watch(input logic sel_cmp, input int n);
    seen = 3'h0;
    repeat (n) begin
      @(posedge pclk);
      #1 seen = seen | (sel_cmp ? cmp : cap);
    end
  endtask

  task automatic pins(input logic [1:0] e2, input logic [1:0] e3,
                      input logic [1:0] ec);
    chk({26'h0, d2, d3a, d3c}, {26'h0, e2, e3, ec});
  endtask

  task automatic match_once();
    tgt = cnt + 16'h0028;
    for (int k = 0; k < 3; k++) apb(1'b1, ADDR_GR2A + 8'(4 * k), {16'h0, tgt});
    watch(1'b1, 60);
    chk({29'h0, seen}, 32'h7);
  endtask

  // Pins change with a frozen counter, so a capture must load c exactly.
  task automatic cap_case(input logic [2:0] v, input logic t,
                          input logic [15:0] c, input logic [2:0] e);
    @(posedge pclk);
    cnt <= c;
    far.drive(v);
    tick <= t;
    // The tick pulse must fall inside the watch window, not before it.
    fork
      watch(1'b0, 12);
      begin
        @(posedge pclk);
        tick <= 1'b0;
      end
    join
    chk({29'h0, seen}, {29'h0, e});
    for (int k = 0; k < 3; k++) begin
      if (e[k]) begin
        rdc(ADDR_GR2A + 8'(4 * k), {16'h0, c});
      end
    end
  endtask

  // ==========================================================
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, tick, run} = 6'h0;
    paddr = '0;
    pwdata = 32'h0;
    cnt = 16'h0;
    {mismatches, tests_run, cycles} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    #1 pins(2'h1, 2'h1, 2'h1);
    rdc(ADDR_MODE, 32'h0);
    rdc(ADDR_GR3C, 32'h0000FFFF);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    run <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ADDR_MODE, m3(4'(i)));
      @(posedge pclk);
      ex = {i[2], i[1:0] == 2'h0};
      #1 pins(ex, ex, ex);
      if (i[1:0] != 2'h0) begin
        match_once();
        ex = {i[1:0] == 2'h1 ? 1'b0 : i[1:0] == 2'h2 ? 1'b1 : ~i[2], 1'b0};
        pins(ex, ex, ex);
        if (i[1:0] == 2'h3) begin
          match_once();
          pins({i[2], 1'b0}, {i[2], 1'b0}, {i[2], 1'b0});
        end
      end
    end
    run <= 1'b0;
    apb(1'b1, ADDR_MODE, 32'h0);
    repeat (8) @(posedge pclk);
    apb(1'b1, ADDR_MODE, m3(4'h8));
    cap_case(3'h0, 1'b0, 16'h1111, 3'h0);
    cap_case(3'h7, 1'b0, 16'h1234, 3'h7);
    cap_case(3'h0, 1'b0, 16'h2345, 3'h0);
    apb(1'b1, ADDR_MODE, m3(4'h9));
    cap_case(3'h7, 1'b0, 16'h3456, 3'h0);
    cap_case(3'h0, 1'b0, 16'h4567, 3'h7);
    apb(1'b1, ADDR_MODE, m3(4'hA));
    cap_case(3'h7, 1'b0, 16'h5678, 3'h7);
    cap_case(3'h0, 1'b0, 16'h6789, 3'h7);
    cap_case(3'h4, 1'b0, 16'h789A, 3'h4);
    cap_case(3'h0, 1'b0, 16'h89AB, 3'h4);
    apb(1'b1, ADDR_MODE, m3(4'hB));
    cap_case(3'h7, 1'b0, 16'h9ABC, 3'h7);
    rdc(ADDR_STAT, 32'h70);
    cap_case(3'h0, 1'b0, 16'hABCD, 3'h7);
    apb(1'b1, ADDR_MODE, m3(4'hC));
    cap_case(3'h0, 1'b1, 16'hBCDE, 3'h6);
    cap_case(3'h7, 1'b0, 16'hCDEF, 3'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rdc(ADDR_CTRL, 32'h1);
    apb(1'b1, ADDR_MODE, m3(4'hA));
    cap_case(3'h0, 1'b0, 16'hDEF0, 3'h3);
    rdc(ADDR_GR3C, 32'h0000BCDE);
    apb(1'b1, ADDR_MODE, m3(4'h1));
    @(posedge pclk);
    #1 pins(2'h0, 2'h0, 2'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
